// *** smi_core.sv ***
// Purpose: Shift, move and indirect load execution with APB access
// Assumes: APB master on pclk; one command per APB write
// Notes: Indirect addresses mirror onto the 128-byte file space
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module smi_core
	import smi_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Core state
	output logic [7:0] work_out,
	output logic carry_out,
	output logic zero_out
);

	logic [7:0] work_reg;
	logic carry_reg;
	logic zero_reg;
	logic [15:0] ptr0_reg;
	logic [15:0] ptr1_reg;
	logic [6:0] faddr_reg;
	logic [CMD_W-1:0] cmd_reg;
	logic [7:0] file_mem [FILE_DEPTH];
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;

	logic wr_en;
	logic cmd_wr;
	logic [CMD_W-1:0] cmd_in;
	smi_op_t op;
	logic dest_file;
	logic [6:0] f_idx;
	logic [7:0] src_val;
	logic [15:0] sel_ptr;
	logic [15:0] ptr_upd;
	logic [15:0] ea;
	logic [7:0] ld_data;
	logic [31:0] rd_val;
	logic rd_hit;
	logic is_shift;
	logic is_mov;
	logic is_ld;

	smi_alu_if alu_bus();

	smi_alu smi_alu_inst (
		.bus(alu_bus.alu)
	);

	function automatic smi_op_t decode_op(input logic [1:0] code);
		case (code)
			OPC_LSL: decode_op = LOGICAL_SHIFT_LEFT_OP;
			OPC_LSR: decode_op = LOGICAL_SHIFT_RIGHT_OP;
			OPC_MOV: decode_op = REGISTER_MOVE_OP;
			default: decode_op = INDIRECT_LOAD_OP;
		endcase
	endfunction

	// Indirect names redirect through a pointer; their own cells still hold data reached by pointer or file window
	function automatic logic [6:0] resolve(input logic [6:0] f,
		input logic [15:0] p0, input logic [15:0] p1);
		if (f == IND0_ADDR)
			resolve = p0[6:0];
		else if (f == IND1_ADDR)
			resolve = p1[6:0];
		else
			resolve = f;
	endfunction

	assign wr_en = psel && penable && pwrite && pready_reg;
	assign cmd_wr = wr_en && (paddr == ADDR_CMD);
	assign cmd_in = pwdata[CMD_W-1:0];
	assign alu_bus.op = op;
	assign alu_bus.src = src_val;

	// Decode and operand fetch for the command arriving this cycle
	always_comb
	begin
		op = decode_op(cmd_in[CMD_OP_LSB +: 2]);
		dest_file = cmd_in[CMD_D_BIT];
		is_shift = cmd_wr && (op == LOGICAL_SHIFT_LEFT_OP ||
			op == LOGICAL_SHIFT_RIGHT_OP);
		is_mov = cmd_wr && (op == REGISTER_MOVE_OP);
		is_ld = cmd_wr && (op == INDIRECT_LOAD_OP);
		f_idx = resolve(cmd_in[CMD_F_LSB +: 7], ptr0_reg, ptr1_reg);
		src_val = file_mem[f_idx];
		sel_ptr = cmd_in[CMD_N_BIT] ? ptr1_reg : ptr0_reg;
		case (cmd_in[CMD_MODE_LSB +: 2])
			MODE_PREINC:
			begin
				ptr_upd = sel_ptr + 16'h0001;
				ea = ptr_upd;
			end
			MODE_PREDEC:
			begin
				ptr_upd = sel_ptr - 16'h0001;
				ea = ptr_upd;
			end
			MODE_POSTINC:
			begin
				ptr_upd = sel_ptr + 16'h0001;
				ea = sel_ptr;
			end
			default:
			begin
				ptr_upd = sel_ptr - 16'h0001;
				ea = sel_ptr;
			end
		endcase
		if (cmd_in[CMD_REL_BIT])
		begin
			ea = sel_ptr + {{10{cmd_in[CMD_K_LSB + 5]}},
				cmd_in[CMD_K_LSB +: 6]};
			ptr_upd = sel_ptr;
		end
		// Only low bits reach the file space; upper bits are ignored
		ld_data = file_mem[ea[6:0]];
	end

	// Work register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			work_reg <= WORK_RST;
		else if (wr_en && paddr == ADDR_WORK)
			work_reg <= pwdata[7:0];
		else if (is_ld)
			work_reg <= ld_data;
		else if ((is_shift || is_mov) && !dest_file)
			work_reg <= alu_bus.res;
	end

	// File space storage
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < FILE_DEPTH; i++)
				file_mem[i] <= FILE_RST;
		end
		else if (wr_en && paddr == ADDR_FDATA)
			file_mem[faddr_reg] <= pwdata[7:0];
		else if ((is_shift || is_mov) && dest_file)
			file_mem[f_idx] <= alu_bus.res;
	end

	// Status flags
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			carry_reg <= 1'b0;
			zero_reg <= 1'b0;
		end
		else if (wr_en && paddr == ADDR_STATUS)
		begin
			carry_reg <= pwdata[STAT_C_BIT];
			zero_reg <= pwdata[STAT_Z_BIT];
		end
		else if (is_shift || is_mov)
		begin
			if (alu_bus.carry_we)
				carry_reg <= alu_bus.carry;
			zero_reg <= alu_bus.zero;
		end
		else if (is_ld)
			zero_reg <= (ld_data == 8'h00);
	end

	// Pointers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ptr0_reg <= PTR_RST;
			ptr1_reg <= PTR_RST;
		end
		else if (wr_en && paddr == ADDR_PTR0)
			ptr0_reg <= pwdata[15:0];
		else if (wr_en && paddr == ADDR_PTR1)
			ptr1_reg <= pwdata[15:0];
		else if (is_ld && !cmd_in[CMD_N_BIT])
			ptr0_reg <= ptr_upd;
		else if (is_ld && cmd_in[CMD_N_BIT])
			ptr1_reg <= ptr_upd;
	end

	// Last command and file window address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cmd_reg <= CMD_RST;
			faddr_reg <= 7'h00;
		end
		else if (cmd_wr)
			cmd_reg <= cmd_in;
		else if (wr_en && paddr == ADDR_FADDR)
			faddr_reg <= pwdata[6:0];
	end

	// Read mux
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_hit = 1'b1;
		case (paddr)
			ADDR_CMD: rd_val = {12'h000, cmd_reg};
			ADDR_WORK: rd_val = {24'h000000, work_reg};
			ADDR_STATUS: rd_val = {30'h0, zero_reg, carry_reg};
			ADDR_PTR0: rd_val = {16'h0000, ptr0_reg};
			ADDR_PTR1: rd_val = {16'h0000, ptr1_reg};
			ADDR_FADDR: rd_val = {25'h0, faddr_reg};
			ADDR_FDATA: rd_val = {24'h000000, file_mem[faddr_reg]};
			default: rd_hit = 1'b0;
		endcase
	end

	// APB answer: ready in the first access cycle, data latched at setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
		else if (psel && !penable)
		begin
			pready_reg <= 1'b1;
			pslverr_reg <= !rd_hit;
			prdata_reg <= pwrite ? 32'h00000000 : rd_val;
		end
		else
		begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign work_out = work_reg;
	assign carry_out = carry_reg;
	assign zero_out = zero_reg;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic src_b7;
	logic src_b0;
	assign src_b7 = src_val[7];
	assign src_b0 = src_val[0];

	sequence s_setup_cmd;
		psel && !penable && pwrite && paddr == ADDR_CMD;
	endsequence

	sequence s_exec;
		s_setup_cmd ##1 (psel && penable && pready_reg);
	endsequence

	a_lsl_carry: assert property (s_exec ##0
		op == LOGICAL_SHIFT_LEFT_OP |=> carry_reg == $past(src_b7))
		else $error("left shift carry wrong");
	a_lsl_fill: assert property (s_exec ##0 is_shift &&
		op == LOGICAL_SHIFT_LEFT_OP && !dest_file |=> !work_reg[0])
		else $error("left shift lsb not zero");
	a_dest_file: assert property (s_exec ##0 is_shift &&
		dest_file |=> work_reg == $past(work_reg))
		else $error("shift to file touched work");
	a_lsr_carry: assert property (s_exec ##0
		op == LOGICAL_SHIFT_RIGHT_OP |=> carry_reg == $past(src_b0))
		else $error("right shift carry wrong");
	a_lsr_fill: assert property (s_exec ##0
		op == LOGICAL_SHIFT_RIGHT_OP && !dest_file |=> !work_reg[7])
		else $error("right shift msb not zero");
	a_mov_work: assert property (s_exec ##0 is_mov &&
		!dest_file |=> work_reg == $past(src_val))
		else $error("move to work wrong");
	a_mov_zero: assert property (s_exec ##0 is_mov |=>
		zero_reg == ($past(src_val) == 8'h00)
		&& carry_reg == $past(carry_reg))
		else $error("move zero flag wrong");
	a_preinc: assert property (s_exec ##0 is_ld &&
		!cmd_in[CMD_REL_BIT] && cmd_in[CMD_N_BIT] &&
		cmd_in[CMD_MODE_LSB +: 2] == MODE_PREINC |=>
		ptr1_reg == $past(ptr1_reg) + 16'h0001)
		else $error("pre-increment wrong");
	a_rel_keep: assert property (s_exec ##0 is_ld &&
		cmd_in[CMD_REL_BIT] |=> ptr0_reg == $past(ptr0_reg) &&
		ptr1_reg == $past(ptr1_reg))
		else $error("relative form moved pointer");
	a_ld_result: assert property (s_exec ##0 is_ld |=>
		work_reg == $past(ld_data) && zero_reg == (work_reg == 8'h00))
		else $error("indirect load result wrong");
	a_ptr_wrap: assert property (s_exec ##0 is_ld &&
		!cmd_in[CMD_REL_BIT] && cmd_in[CMD_N_BIT] &&
		cmd_in[CMD_MODE_LSB +: 2] == MODE_POSTINC &&
		ptr1_reg == 16'hffff |=> ptr1_reg == 16'h0000)
		else $error("pointer wrap wrong");
	a_ld_carry: assert property (s_exec ##0 is_ld |=>
		carry_reg == $past(carry_reg))
		else $error("load changed carry");
	// A right-shifted nonzero value differs from its source, so a late write shows
	a_one_cycle: assert property (s_exec ##0 is_shift &&
		dest_file && op == LOGICAL_SHIFT_RIGHT_OP |=>
		file_mem[$past(f_idx)] == ($past(src_val) >> 1))
		else $error("shift to file not done in one cycle");

endmodule
`default_nettype wire

// *** smi_pkg.sv ***
// Purpose: Shared constants and types for the shift/move/indirect unit
// Assumes: 8-bit data path, 7-bit file index, 16-bit pointers
// Notes: APB byte offsets, command fields, reset values
package smi_pkg;

	// APB register byte offsets
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_WORK = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_PTR0 = 8'h0c;
	localparam logic [7:0] ADDR_PTR1 = 8'h10;
	localparam logic [7:0] ADDR_FADDR = 8'h14;
	localparam logic [7:0] ADDR_FDATA = 8'h18;

	// Command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_D_BIT = 2;
	localparam int CMD_F_LSB = 3;
	localparam int CMD_N_BIT = 10;
	localparam int CMD_MODE_LSB = 11;
	localparam int CMD_REL_BIT = 13;
	localparam int CMD_K_LSB = 14;
	localparam int CMD_W = 20;

	// Status fields
	localparam int STAT_C_BIT = 0;
	localparam int STAT_Z_BIT = 1;

	// Reset values
	localparam logic [7:0] WORK_RST = 8'h00;
	localparam logic [15:0] PTR_RST = 16'h0000;
	localparam logic [7:0] FILE_RST = 8'h00;
	localparam logic [19:0] CMD_RST = 20'h00000;

	// File space
	localparam int FILE_DEPTH = 128;
	localparam logic [6:0] IND0_ADDR = 7'h00;
	localparam logic [6:0] IND1_ADDR = 7'h01;

	// Opcode field codes
	localparam logic [1:0] OPC_LSL = 2'h0;
	localparam logic [1:0] OPC_LSR = 2'h1;
	localparam logic [1:0] OPC_MOV = 2'h2;
	localparam logic [1:0] OPC_LD = 2'h3;

	// Pointer update mode codes
	localparam logic [1:0] MODE_PREINC = 2'h0;
	localparam logic [1:0] MODE_PREDEC = 2'h1;
	localparam logic [1:0] MODE_POSTINC = 2'h2;
	localparam logic [1:0] MODE_POSTDEC = 2'h3;

	typedef enum logic [3:0] {
		LOGICAL_SHIFT_LEFT_OP = 4'b0001,
		LOGICAL_SHIFT_RIGHT_OP = 4'b0010,
		REGISTER_MOVE_OP = 4'b0100,
		INDIRECT_LOAD_OP = 4'b1000
	} smi_op_t;

endpackage

// *** smi_alu_if.sv ***
// Purpose: Carrier between the core and its shift/move unit
// Assumes: Purely combinational exchange
// Notes: Core drives operation and operand
`timescale 1ns/10ps
`default_nettype none
interface smi_alu_if;
	import smi_pkg::*;
	smi_op_t op;
	logic [7:0] src;
	logic [7:0] res;
	logic carry;
	logic carry_we;
	logic zero;
	modport core (output op, output src, input res, input carry,
		input carry_we, input zero);
	modport alu (input op, input src, output res, output carry,
		output carry_we, output zero);
endinterface
`default_nettype wire

// *** smi_alu.sv ***
// Purpose: Shift and move result, carry and zero generation
// Assumes: Operand already resolved to a file location
// Notes: Combinational only
`timescale 1ns/10ps
`default_nettype none
module smi_alu
	import smi_pkg::*;
(
	// Core side
	smi_alu_if.alu bus
);

	always_comb
	begin
		bus.res = bus.src;
		bus.carry = 1'b0;
		bus.carry_we = 1'b0;
		case (bus.op)
			LOGICAL_SHIFT_LEFT_OP:
			begin
				bus.res = {bus.src[6:0], 1'b0};
				bus.carry = bus.src[7];
				bus.carry_we = 1'b1;
			end
			LOGICAL_SHIFT_RIGHT_OP:
			begin
				bus.res = {1'b0, bus.src[7:1]};
				bus.carry = bus.src[0];
				bus.carry_we = 1'b1;
			end
			REGISTER_MOVE_OP:
			begin
				bus.res = bus.src;
			end
			default:
			begin
				bus.res = bus.src;
			end
		endcase
		bus.zero = (bus.res == 8'h00);
	end

endmodule
`default_nettype wire

// *** tb_shift_move_indirect_ops.sv ***
// Purpose: Self-checking bench for the shift/move/indirect unit
// Assumes: Zero-wait APB slave, command results one edge after write
// Notes: Pointer tests wrap through ffff to catch width slips
`timescale 1ns/10ps
`default_nettype none
module tb_shift_move_indirect_ops
	import smi_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] work_out;
	logic carry_out;
	logic zero_out;
	int err_total = 0;
	int n_tests = 0;
	logic [31:0] rdata;
	logic rerr;
	logic [7:0] ld_w [4] = '{8'h33, 8'h11, 8'h22, 8'h22};
	logic [15:0] ld_p [4] = '{16'h0000, 16'hfffe, 16'h0000, 16'hfffe};

	always #5 pclk = ~pclk;

	smi_core smi_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .work_out(work_out), .carry_out(carry_out),
		.zero_out(zero_out));

	task automatic give_verdict();
	begin
		$display("Comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask

	// Request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t;
	begin
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do
		begin
			@(posedge pclk);
			t++;
		end
		while (pready !== 1'b1 && t < 50);
		if (t >= 50)
			chk(32'h0, 32'h1);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
	begin
		apb(1'b1, a, d);
		chk({31'h0, rerr}, 32'h0);
	end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
	begin
		apb(1'b0, a, 32'h0);
		chk(rdata, exp);
		chk({31'h0, rerr}, 32'h0);
	end
	endtask

	task automatic setf(input logic [6:0] a, input logic [7:0] v);
	begin
		wr(ADDR_FADDR, {25'h0, a});
		wr(ADDR_FDATA, {24'h0, v});
	end
	endtask

	task automatic getf(input logic [6:0] a, input logic [7:0] v);
	begin
		wr(ADDR_FADDR, {25'h0, a});
		rd(ADDR_FDATA, {24'h0, v});
	end
	endtask

	function automatic logic [31:0] cmd(input logic [1:0] op,
		input logic d, input logic [6:0] f, input logic n,
		input logic [1:0] m, input logic rel, input logic [5:0] k);
		cmd = 32'h0;
		cmd[CMD_OP_LSB +: 2] = op;
		cmd[CMD_D_BIT] = d;
		cmd[CMD_F_LSB +: 7] = f;
		cmd[CMD_N_BIT] = n;
		cmd[CMD_MODE_LSB +: 2] = m;
		cmd[CMD_REL_BIT] = rel;
		cmd[CMD_K_LSB +: 6] = k;
	endfunction

	// Results must show the cycle after the command is taken
	task automatic exec(input logic [31:0] c, input logic [7:0] w,
		input logic cy, input logic z);
	begin
		wr(ADDR_CMD, c);
		@(posedge pclk);
		chk({24'h0, work_out}, {24'h0, w});
		chk({31'h0, carry_out}, {31'h0, cy});
		chk({31'h0, zero_out}, {31'h0, z});
	end
	endtask

	task automatic t_reset();
	begin
		rd(ADDR_WORK, 32'h0);
		rd(ADDR_STATUS, 32'h0);
		rd(ADDR_PTR0, 32'h0);
		rd(ADDR_PTR1, 32'h0);
	end
	endtask

	task automatic t_shifts();
	begin
		setf(7'h05, 8'h81);
		exec(cmd(OPC_LSL, 0, 7'h05, 0, 0, 0, 0), 8'h02, 1, 0);
		getf(7'h05, 8'h81);
		setf(7'h06, 8'h80);
		exec(cmd(OPC_LSL, 1, 7'h06, 0, 0, 0, 0), 8'h02, 1, 1);
		getf(7'h06, 8'h00);
		setf(7'h07, 8'h01);
		exec(cmd(OPC_LSR, 0, 7'h07, 0, 0, 0, 0), 8'h00, 1, 1);
		setf(7'h07, 8'hfe);
		exec(cmd(OPC_LSR, 1, 7'h07, 0, 0, 0, 0), 8'h00, 0, 0);
		getf(7'h07, 8'h7f);
	end
	endtask

	task automatic t_move();
	begin
		wr(ADDR_STATUS, 32'h1);
		setf(7'h08, 8'h00);
		exec(cmd(OPC_MOV, 1, 7'h08, 0, 0, 0, 0), 8'h00, 1, 1);
		setf(7'h09, 8'hc3);
		exec(cmd(OPC_MOV, 0, 7'h09, 0, 0, 0, 0), 8'hc3, 1, 0);
		getf(7'h09, 8'hc3);
	end
	endtask

	// Carry is preset so a pointer update that touches flags shows up
	task automatic t_load();
		int m;
	begin
		setf(7'h7e, 8'h11);
		setf(7'h7f, 8'h22);
		setf(7'h00, 8'h33);
		setf(7'h10, 8'h00);
		wr(ADDR_STATUS, 32'h1);
		for (m = 0; m < 4; m++)
		begin
			wr(ADDR_PTR1, 32'hffff);
			exec(cmd(OPC_LD, 0, 0, 1, m[1:0], 0, 0), ld_w[m], 1, 0);
			rd(ADDR_PTR1, {16'h0, ld_p[m]});
		end
		wr(ADDR_PTR0, 32'h0030);
		exec(cmd(OPC_LD, 0, 0, 0, 0, 1, 6'h20), 8'h00, 1, 1);
		rd(ADDR_PTR0, 32'h0030);
		wr(ADDR_PTR0, 32'h0060);
		exec(cmd(OPC_LD, 0, 0, 0, 0, 1, 6'h1f), 8'h22, 1, 0);
	end
	endtask

	task automatic t_indirect();
	begin
		wr(ADDR_PTR0, 32'h007f);
		exec(cmd(OPC_LSR, 1, IND0_ADDR, 0, 0, 0, 0), 8'h22, 0, 0);
		getf(7'h7f, 8'h11);
		wr(ADDR_PTR1, 32'h107e);
		exec(cmd(OPC_MOV, 0, IND1_ADDR, 0, 0, 0, 0), 8'h11, 0, 0);
		rd(ADDR_CMD, 32'h0000000a);
	end
	endtask

	task automatic t_unmapped();
	begin
		apb(1'b1, 8'h1c, 32'hffffffff);
		chk({31'h0, rerr}, 32'h1);
		apb(1'b0, 8'h1c, 32'h0);
		chk({31'h0, rerr}, 32'h1);
		chk(rdata, 32'h0);
		rd(ADDR_WORK, 32'h11);
		wr(ADDR_WORK, 32'hffffff5a);
		rd(ADDR_WORK, 32'h5a);
	end
	endtask

	// Whole run is about 70 transfers; this only catches a hang
	initial
	begin
		repeat (8000) @(posedge pclk);
		err_total++;
		give_verdict();
	end

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_shifts();
		t_move();
		t_load();
		t_indirect();
		t_unmapped();
		give_verdict();
	end
endmodule
`default_nettype wire
